// ==== design/bfs_pkg.sv ====
// Package with constants and types for the buck fault supervisor.
package bfs_pkg;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned UV_DELAY_US      = 16;
  localparam int unsigned UV_DELAY_CYC     = UV_DELAY_US * CLK_MHZ;
  localparam int unsigned HICCUP_MS        = 56;
  localparam int unsigned HICCUP_CYC       = HICCUP_MS * 1000 * CLK_MHZ;
  localparam int unsigned PG_DELAY_MS      = 1;
  localparam int unsigned PG_DELAY_CYC     = PG_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W            = 24;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic        STRAP_HICCUP_RST = 1'b0;
  localparam logic        STRAP_SKIP_RST   = 1'b0;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_SOFT    = 3'b001,
    ST_RUN     = 3'b011,
    ST_OV_DIS  = 3'b010,
    ST_LATCH   = 3'b110,
    ST_SLEEP   = 3'b111,
    ST_PS_HOT  = 3'b101
  } bfs_state_type;

  typedef struct packed {
    logic high_side_on;
    logic low_side_on;
    logic switching;
  } bfs_gate_type;

  typedef struct packed {
    logic uv_cmp;
    logic ov_cmp;
    logic neg_lim;
    logic discharged;
    logic zero_cross;
    logic ps_hot;
    logic ctl_hot;
    logic pwr_in_ok;
  } bfs_sense_type;

endpackage : bfs_pkg

// ==== design/bfs_delay_timer.sv ====
// Restartable cycle counter that holds done high from the target count until run drops.
`timescale 1ns/1ps
module bfs_delay_timer
  import bfs_pkg::*;
#(
  parameter int unsigned TARGET = 16
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  output logic      done
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             done_reg;
  logic             done_next;

  always_comb begin
    count_next = '0;
    done_next  = 1'b0;
    if (run) begin
      if (count_reg >= CNT_W'(TARGET - 1)) begin
        count_next = count_reg;
        done_next  = 1'b1;
      end else begin
        count_next = count_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end

  assign done = done_reg;

endmodule : bfs_delay_timer

// ==== design/buck_fault_supervisor.sv ====
// Fault supervisor and start-up sequencer for a step-down power stage.
`timescale 1ns/1ps
// Notes on behaviour
// - Feedback at or below 600 mV starts the undervoltage qualification count.
// - After 16 us qualified undervoltage, apply strapped latch-off or hiccup.
// - Latch-off holds both switches off until supply cycle or enable toggle.
// - Hiccup sleeps 56 ms then restarts, with unlimited retries.
// - Undervoltage detection is ignored until soft-start completes.
// - Undervoltage recovery clears the count; next drop counts from zero.
// - Feedback at 950 mV forces high side off, low side on until limit.
// - At negative limit, low side off, high side on for one on-time.
// - While discharge is sensed, hold high side off and low side on.
// - Hiccup overvoltage still discharges; sleep counter starts at detection.
// - Overvoltage detection is ignored until soft-start completes.
// - Power stage overheat stops switching; cool-down restarts with soft-start.
// - Controller overheat stops switching and applies strapped response.
// - Power good high only in target; low when disabled or input low.
// - Power good enabled only after soft-start and a further 1 ms.
// - Forced continuous mode keeps continuous conduction at all loads.
// - Pulse-skip mode turns low side off at zero inductor current.
// - Discontinuous on-time stays equal to the continuous on-time.
// - Start works whichever of input supply and enable comes first.
// - Straps sampled once at power-up; enable toggling does not resample.
module buck_fault_supervisor
  import bfs_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = HICCUP_CYC,
  parameter int unsigned PG_CYCLES     = PG_DELAY_CYC,
  parameter int unsigned UV_CYCLES     = UV_DELAY_CYC
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          enable_pin,
  input  wire logic          strap_hiccup_pin,
  input  wire logic          strap_skip_pin,
  input  wire logic          soft_start_done,
  input  wire logic          on_time_done,
  input  wire logic          pwm_high_req,
  input  wire bfs_sense_type sense,
  output bfs_gate_type       gate,
  output logic               soft_start_go,
  output logic               pulse_skip_mode,
  output logic               power_good_out,
  output logic               power_good_oe_n,
  output logic               fault_latched
);

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  localparam int unsigned NSYNC = 11;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;

  assign raw = {enable_pin, strap_hiccup_pin, strap_skip_pin,
                soft_start_done, on_time_done, pwm_high_req,
                sense.uv_cmp, sense.ov_cmp, sense.neg_lim,
                sense.ps_hot, sense.ctl_hot};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end

  logic en_s, hic_s, skip_s, ss_done_s, ton_done_s, pwm_s;
  logic uv_s, ov_s, neg_s, ps_hot_s, ctl_hot_s;
  logic [2:0] misc_s1_reg;
  logic [2:0] misc_s2_reg;
  logic       dis_s, zc_s, pin_ok_s;

  assign {en_s, hic_s, skip_s, ss_done_s, ton_done_s, pwm_s,
          uv_s, ov_s, neg_s, ps_hot_s, ctl_hot_s} = s2_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      misc_s1_reg <= '0;
      misc_s2_reg <= '0;
    end else begin
      misc_s1_reg <= {sense.discharged, sense.zero_cross, sense.pwr_in_ok};
      misc_s2_reg <= misc_s1_reg;
    end
  end

  assign {dis_s, zc_s, pin_ok_s} = misc_s2_reg;

  // ****************************************************************
  // Strap capture, once after reset release.
  // ****************************************************************
  logic strap_done_reg, strap_done_next;
  logic strap_hic_reg, strap_hic_next;
  logic strap_skip_reg, strap_skip_next;
  logic [1:0] strap_wait_reg, strap_wait_next;

  always_comb begin
    strap_done_next = strap_done_reg;
    strap_hic_next  = strap_hic_reg;
    strap_skip_next = strap_skip_reg;
    strap_wait_next = strap_wait_reg;
    if (!strap_done_reg) begin
      if (strap_wait_reg == 2'h3) begin
        strap_done_next = 1'b1;
        strap_hic_next  = hic_s;
        strap_skip_next = skip_s;
      end else begin
        strap_wait_next = strap_wait_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      strap_hic_reg  <= STRAP_HICCUP_RST;
      strap_skip_reg <= STRAP_SKIP_RST;
      strap_wait_reg <= 2'h0;
    end else begin
      strap_done_reg <= strap_done_next;
      strap_hic_reg  <= strap_hic_next;
      strap_skip_reg <= strap_skip_next;
      strap_wait_reg <= strap_wait_next;
    end
  end

  // ****************************************************************
  // Timers.
  // ****************************************************************
  bfs_state_type state_reg, state_next;
  logic uv_run, uv_done, sleep_run, sleep_done, pg_run, pg_done;
  logic armed;

  assign armed  = (state_reg == ST_RUN);
  assign uv_run = armed && uv_s;

  bfs_delay_timer #(.TARGET(UV_CYCLES)) u_uv_timer (
    .clock (clock),
    .rst   (rst),
    .run   (uv_run),
    .done  (uv_done)
  );

  bfs_delay_timer #(.TARGET(HICCUP_CYCLES)) u_sleep_timer (
    .clock (clock),
    .rst   (rst),
    .run   (sleep_run),
    .done  (sleep_done)
  );

  assign pg_run = armed && pin_ok_s;

  bfs_delay_timer #(.TARGET(PG_CYCLES)) u_pg_timer (
    .clock (clock),
    .rst   (rst),
    .run   (pg_run),
    .done  (pg_done)
  );

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  logic ov_hiccup_reg, ov_hiccup_next;
  logic hs_reg, hs_next;
  logic ls_reg, ls_next;
  logic sw_reg, sw_next;
  logic pg_reg, pg_next;
  logic go;

  assign go = en_s && pin_ok_s && strap_done_reg;
  assign sleep_run = (state_reg == ST_SLEEP) ||
                     (state_reg == ST_OV_DIS && ov_hiccup_reg);

  always_comb begin
    state_next     = state_reg;
    ov_hiccup_next = ov_hiccup_reg;
    if (!go) begin
      state_next     = ST_OFF;
      ov_hiccup_next = 1'b0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_next = ST_SOFT;
        end
        ST_SOFT: begin
          if (ps_hot_s) begin
            state_next = ST_PS_HOT;
          end else if (ctl_hot_s) begin
            state_next = strap_hic_reg ? ST_SLEEP : ST_LATCH;
          end else if (ss_done_s) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (ov_s) begin
            state_next     = ST_OV_DIS;
            ov_hiccup_next = strap_hic_reg;
          end else if (ps_hot_s) begin
            state_next = ST_PS_HOT;
          end else if (ctl_hot_s || uv_done) begin
            state_next = strap_hic_reg ? ST_SLEEP : ST_LATCH;
          end
        end
        ST_OV_DIS: begin
          if (ov_hiccup_reg && sleep_done) begin
            state_next     = ST_SOFT;
            ov_hiccup_next = 1'b0;
          end
        end
        ST_SLEEP: begin
          if (sleep_done) begin
            state_next = ST_SOFT;
          end
        end
        ST_PS_HOT: begin
          if (!ps_hot_s) begin
            state_next = ST_SOFT;
          end
        end
        ST_LATCH: begin
          state_next = ST_LATCH;
        end
        default: begin
          state_next = ST_OFF;
        end
      endcase
    end
  end

  // Gate drive, mode and power good.
  always_comb begin
    hs_next = 1'b0;
    ls_next = 1'b0;
    sw_next = 1'b0;
    pg_next = 1'b0;
    case (state_next)
      ST_SOFT, ST_RUN: begin
        sw_next = 1'b1;
        hs_next = pwm_s;
        ls_next = !pwm_s;
        if (strap_skip_reg && zc_s && !pwm_s) begin
          ls_next = 1'b0;
        end
      end
      ST_OV_DIS: begin
        if (dis_s) begin
          ls_next = 1'b1;
        end else if (hs_reg && state_reg == ST_OV_DIS) begin
          hs_next = !ton_done_s;
          ls_next = ton_done_s;
        end else if (neg_s) begin
          hs_next = 1'b1;
        end else begin
          ls_next = 1'b1;
        end
      end
      default: begin
        hs_next = 1'b0;
        ls_next = 1'b0;
      end
    endcase
    if (state_reg == ST_RUN && state_next == ST_RUN && pg_done &&
        !uv_s && !ov_s) begin
      pg_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_OFF;
      ov_hiccup_reg <= 1'b0;
      hs_reg        <= 1'b0;
      ls_reg        <= 1'b0;
      sw_reg        <= 1'b0;
      pg_reg        <= 1'b0;
    end else begin
      state_reg     <= state_next;
      ov_hiccup_reg <= ov_hiccup_next;
      hs_reg        <= hs_next;
      ls_reg        <= ls_next;
      sw_reg        <= sw_next;
      pg_reg        <= pg_next;
    end
  end

  assign gate.high_side_on = hs_reg;
  assign gate.low_side_on  = ls_reg;
  assign gate.switching    = sw_reg;
  assign soft_start_go     = (state_reg == ST_SOFT);
  assign pulse_skip_mode   = strap_skip_reg;
  assign power_good_out    = 1'b0;
  assign power_good_oe_n   = pg_reg;
  assign fault_latched     = (state_reg == ST_LATCH);

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  property p_latch_off;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_LATCH) |=> (!hs_reg && !ls_reg);
  endproperty
  a_latch_off: assert property (p_latch_off)
    else $error("Latch-off state drives a switch.");

  property p_ov_hs_off;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_RUN && ov_s && go) |=> !hs_reg;
  endproperty
  a_ov_hs_off: assert property (p_ov_hs_off)
    else $error("High side not forced off on overvoltage.");

  property p_no_uv_soft;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_SOFT && uv_s) |-> (!uv_run && !uv_done);
  endproperty
  a_no_uv_soft: assert property (p_no_uv_soft)
    else $error("Undervoltage counted during soft-start.");

  property p_no_ov_soft;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_SOFT && go && !ps_hot_s && !ctl_hot_s)
        |=> state_reg != ST_OV_DIS;
  endproperty
  a_no_ov_soft: assert property (p_no_ov_soft)
    else $error("Overvoltage acted on during soft-start.");

  property p_pg_low_off;
    @(posedge clock) disable iff (rst)
      (!en_s || !pin_ok_s) |=> !pg_reg;
  endproperty
  a_pg_low_off: assert property (p_pg_low_off)
    else $error("Power good high while disabled.");

  property p_pg_needs_run;
    @(posedge clock) disable iff (rst)
      pg_reg |-> (state_reg == ST_RUN && $past(pg_done));
  endproperty
  a_pg_needs_run: assert property (p_pg_needs_run)
    else $error("Power good before delay expired.");

  property p_uv_fault;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_RUN && uv_done && go && !ov_s && !ps_hot_s)
        |=> (state_reg == ST_LATCH || state_reg == ST_SLEEP);
  endproperty
  a_uv_fault: assert property (p_uv_fault)
    else $error("Qualified undervoltage not acted on.");

  property p_sleep_restart;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_SLEEP && sleep_done && go) |=> state_reg == ST_SOFT;
  endproperty
  a_sleep_restart: assert property (p_sleep_restart)
    else $error("Hiccup did not restart with soft-start.");

  property p_strap_hold;
    @(posedge clock) disable iff (rst)
      strap_done_reg |=> $stable(strap_hic_reg) && $stable(strap_skip_reg);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("Strap changed after capture.");

  c_latch: cover property (@(posedge clock) state_reg == ST_LATCH);
  c_sleep: cover property (@(posedge clock) state_reg == ST_SLEEP);
  c_ovdis: cover property (@(posedge clock) state_reg == ST_OV_DIS);
  c_pg:    cover property (@(posedge clock) pg_reg);

endmodule : buck_fault_supervisor

// ==== dv/bfs_host_model.sv ====
// Host-side model that drives enable and senses the power-good pin.
`timescale 1ns/1ps
module bfs_host_model #(
  parameter bit SPLIT = 1'b0
) (
  input  wire logic clock,
  input  wire logic en_req,
  input  wire logic bias_ok,
  input  wire logic pwr_ok,
  input  wire logic power_good_out,
  input  wire logic power_good_oe_n,
  output logic      enable_pin,
  output logic      pg_level
);
  initial enable_pin = 1'b0;
  // The open-drain pin is pulled up whenever the device releases it.
  assign pg_level = power_good_oe_n ? 1'b1 : power_good_out;
  // Enable moves only at the falling edge.
  always @(negedge clock) begin
    if (SPLIT) begin
      enable_pin <= en_req & bias_ok & pwr_ok;
    end else begin
      enable_pin <= en_req;
    end
  end
endmodule : bfs_host_model

// ==== dv/tb.sv ====
// Self-checking testbench for the buck fault supervisor.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  import bfs_pkg::*;
  localparam int HC = 200;
  localparam int PC = 50;
  localparam int UC = 20;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          en_req = 1'b0;
  logic          strap_hiccup_pin = 1'b0;
  logic          strap_skip_pin = 1'b0;
  logic          soft_start_done = 1'b0;
  logic          on_time_done = 1'b0;
  logic          pwm_high_req = 1'b0;
  bfs_sense_type sense = '0;
  bfs_gate_type  gate;
  logic          enable_pin, soft_start_go, pulse_skip_mode, fault_latched;
  logic          power_good_out, power_good_oe_n, pg_level;
  int            n_errors = 0;
  int            samples_checked = 0;

  always #2 clock = ~clock;

  bfs_host_model host_u (.clock(clock), .en_req(en_req), .bias_ok(1'b1),
    .pwr_ok(sense.pwr_in_ok), .power_good_out(power_good_out),
    .power_good_oe_n(power_good_oe_n), .enable_pin(enable_pin),
    .pg_level(pg_level));

  buck_fault_supervisor #(.HICCUP_CYCLES(HC), .PG_CYCLES(PC),
    .UV_CYCLES(UC)) dut_u (.clock(clock), .rst(rst),
    .enable_pin(enable_pin), .strap_hiccup_pin(strap_hiccup_pin),
    .strap_skip_pin(strap_skip_pin), .soft_start_done(soft_start_done),
    .on_time_done(on_time_done), .pwm_high_req(pwm_high_req),
    .sense(sense), .gate(gate), .soft_start_go(soft_start_go),
    .pulse_skip_mode(pulse_skip_mode), .power_good_out(power_good_out),
    .power_good_oe_n(power_good_oe_n), .fault_latched(fault_latched));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic obs(input int k);
    case (k)
      0: return soft_start_go;
      1: return fault_latched;
      2: return pg_level;
      default: return gate.switching;
    endcase
  endfunction : obs

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic wt(input int k, input logic v, input int lim,
                    input string nm);
    int i;
    i = 0;
    while (obs(k) !== v && i < lim) begin
      @(negedge clock);
      i++;
    end
    `CHK(nm, v, obs(k))
  endtask : wt

  task automatic hold(input int k, input logic v, input int n,
                      input string nm);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge clock);
      if (obs(k) !== v) ok = 1'b0;
    end
    `CHK(nm, 1'b1, ok)
  endtask : hold

  task automatic sw_chk(input logic hi, input logic lo);
    `CHK("high_side_on", hi, gate.high_side_on)
    `CHK("low_side_on", lo, gate.low_side_on)
  endtask : sw_chk

  task automatic hard_reset(input logic hic, input logic skip);
    rst = 1'b1;
    en_req = 1'b0;
    sense = '0;
    strap_hiccup_pin = hic;
    strap_skip_pin = skip;
    cyc(12);
    `CHK("pg_level", 1'b0, pg_level)
    rst = 1'b0;
    cyc(6);
  endtask : hard_reset

  task automatic run_up();
    soft_start_done = 1'b0;
    en_req = 1'b1;
    sense.pwr_in_ok = 1'b1;
    wt(0, 1'b1, 12, "soft_start_go");
    cyc(4);
    soft_start_done = 1'b1;
    wt(0, 1'b0, 8, "soft_start_go");
  endtask : run_up

  task automatic re_enable();
    en_req = 1'b0;
    cyc(6);
    `CHK("fault_latched", 1'b0, fault_latched)
    `CHK("switching", 1'b0, gate.switching)
    `CHK("pg_level", 1'b0, pg_level)
    run_up();
  endtask : re_enable

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_start();
    hard_reset(1'b0, 1'b0);
    en_req = 1'b1;
    hold(0, 1'b0, 20, "soft_start_go");
    sense.pwr_in_ok = 1'b1;
    wt(0, 1'b1, 8, "soft_start_go");
    sense.uv_cmp = 1'b1;
    sense.ov_cmp = 1'b1;
    hold(0, 1'b1, UC + 10, "soft_start_go");
    `CHK("fault_latched", 1'b0, fault_latched)
    `CHK("pg_level", 1'b0, pg_level)
    sense = '0;
    sense.pwr_in_ok = 1'b1;
    soft_start_done = 1'b1;
    wt(0, 1'b0, 8, "soft_start_go");
    sense.zero_cross = 1'b1;
    cyc(5);
    sw_chk(1'b0, 1'b1);
    `CHK("pulse_skip_mode", 1'b0, pulse_skip_mode)
    sense.zero_cross = 1'b0;
    hold(2, 1'b0, PC - 12, "pg_level");
    wt(2, 1'b1, 20, "pg_level");
    $display("test start done errors %0d", n_errors);
  endtask : t_start

  task automatic t_uv();
    repeat (2) begin
      sense.uv_cmp = 1'b1;
      cyc(UC - 8);
      sense.uv_cmp = 1'b0;
      cyc(4);
    end
    `CHK("fault_latched", 1'b0, fault_latched)
    sense.uv_cmp = 1'b1;
    wt(1, 1'b1, UC + 8, "fault_latched");
    sense.uv_cmp = 1'b0;
    hold(1, 1'b1, 30, "fault_latched");
    sw_chk(1'b0, 1'b0);
    `CHK("pg_level", 1'b0, pg_level)
    strap_hiccup_pin = 1'b1;
    strap_skip_pin = 1'b1;
    re_enable();
    `CHK("pulse_skip_mode", 1'b0, pulse_skip_mode)
    sense.uv_cmp = 1'b1;
    wt(1, 1'b1, UC + 8, "fault_latched");
    sense.uv_cmp = 1'b0;
    re_enable();
    $display("test uv done errors %0d", n_errors);
  endtask : t_uv

  task automatic t_ov();
    pwm_high_req = 1'b1;
    cyc(5);
    sw_chk(1'b1, 1'b0);
    sense.ov_cmp = 1'b1;
    cyc(5);
    sw_chk(1'b0, 1'b1);
    sense.neg_lim = 1'b1;
    cyc(5);
    sw_chk(1'b1, 1'b0);
    sense.neg_lim = 1'b0;
    on_time_done = 1'b1;
    cyc(5);
    sw_chk(1'b0, 1'b1);
    on_time_done = 1'b0;
    sense.ov_cmp = 1'b0;
    sense.discharged = 1'b1;
    sense.neg_lim = 1'b1;
    cyc(25);
    sw_chk(1'b0, 1'b1);
    sense.neg_lim = 1'b0;
    sense.discharged = 1'b0;
    pwm_high_req = 1'b0;
    re_enable();
    $display("test ov done errors %0d", n_errors);
  endtask : t_ov

  task automatic t_hiccup();
    hard_reset(1'b1, 1'b1);
    `CHK("pulse_skip_mode", 1'b1, pulse_skip_mode)
    run_up();
    cyc(5);
    sw_chk(1'b0, 1'b1);
    sense.zero_cross = 1'b1;
    cyc(5);
    sw_chk(1'b0, 1'b0);
    sense.zero_cross = 1'b0;
    sense.uv_cmp = 1'b1;
    wt(3, 1'b0, UC + 8, "switching");
    `CHK("fault_latched", 1'b0, fault_latched)
    soft_start_done = 1'b0;
    hold(0, 1'b0, HC - 20, "soft_start_go");
    wt(0, 1'b1, 40, "soft_start_go");
    hold(0, 1'b1, UC + 10, "soft_start_go");
    sense.uv_cmp = 1'b0;
    soft_start_done = 1'b1;
    wt(0, 1'b0, 8, "soft_start_go");
    sense.ov_cmp = 1'b1;
    soft_start_done = 1'b0;
    cyc(5);
    sense.neg_lim = 1'b1;
    cyc(5);
    sw_chk(1'b1, 1'b0);
    sense = '0;
    sense.pwr_in_ok = 1'b1;
    sense.discharged = 1'b1;
    hold(0, 1'b0, HC - 30, "soft_start_go");
    wt(0, 1'b1, 40, "soft_start_go");
    sense.discharged = 1'b0;
    soft_start_done = 1'b1;
    wt(0, 1'b0, 8, "soft_start_go");
    sense.ctl_hot = 1'b1;
    soft_start_done = 1'b0;
    wt(3, 1'b0, 8, "switching");
    sense.ctl_hot = 1'b0;
    hold(0, 1'b0, HC - 20, "soft_start_go");
    wt(0, 1'b1, 40, "soft_start_go");
    soft_start_done = 1'b1;
    wt(0, 1'b0, 8, "soft_start_go");
    sense.ps_hot = 1'b1;
    soft_start_done = 1'b0;
    wt(3, 1'b0, 8, "switching");
    hold(0, 1'b0, 20, "soft_start_go");
    sense.ps_hot = 1'b0;
    wt(0, 1'b1, 10, "soft_start_go");
    soft_start_done = 1'b1;
    wt(2, 1'b1, PC + 20, "pg_level");
    sense.pwr_in_ok = 1'b0;
    wt(2, 1'b0, 8, "pg_level");
    $display("test hiccup done errors %0d", n_errors);
  endtask : t_hiccup

  // ****************************************************************
  // Verdict and run control.
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // The tests need about 1100 cycles; the watchdog allows far more.
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  initial begin
    @(negedge clock);
    t_start();
    t_uv();
    t_ov();
    t_hiccup();
    print_verdict();
  end
endmodule : tb
